// ### design/rts_i2c_slave.sv
// Serial slave transaction logic of a low-power real-time clock
//
// Overview of operation
// - Multi-byte writes fill successive locations
// - Device acknowledges its own address and every byte written after it
// - Reads come from the internal address counter
// - Address-only write loads the address counter
// - Dummy write plus repeated start gives random read
// - Master ACK requests the next read byte
// - Master NACK makes device release SDA
// - Long SCL low resets the serial interface
// - Timeout releases SDA
// - Timeout only while oscillator runs
// - SCL is only an input, never stretched
// - SDA is only pulled low or released
// - Fixed slave address, write d0 read d1
// - Address mismatch ignores bus until next start
// - Byte after slave write address is memory address
// - Sample on SCL rise, shift on fall, MSB first
module rts_i2c_slave #(
  parameter int unsigned TIMEOUT_CYCLES = rts_pkg::SCL_LOW_LIMIT_MAX_CYC,
  parameter int unsigned MEM_DEPTH = rts_pkg::MEM_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic osc_run,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic bus_timeout
);
  import rts_pkg::*;

  localparam int IDX_W = $clog2(MEM_DEPTH);
  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);
  localparam logic [TO_W-1:0] TO_FULL = TO_W'(TIMEOUT_CYCLES);
  localparam logic [TO_W-1:0] TO_ZERO = TO_W'(0);

  // ***********************************************
  // Pin synchronisation
  // ***********************************************
  logic [2:0] lvl, rise_v, fall_v;

  rts_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({osc_run, sda_in, scl_in}),
    .level(lvl),
    .rise(rise_v),
    .fall(fall_v)
  );

  logic scl, sda, osc, scl_rise, scl_fall, start_det, stop_det;
  assign scl = lvl[0];
  assign sda = lvl[1];
  assign osc = lvl[2];
  assign scl_rise = rise_v[0];
  assign scl_fall = fall_v[0];
  assign start_det = scl & fall_v[1];
  assign stop_det = scl & rise_v[1];

  // ***********************************************
  // State
  // ***********************************************
  rts_state_t state, next_state;
  rts_kind_t kind, next_kind;
  logic rw, next_rw;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] tx, next_tx;
  logic [7:0] ptr, next_ptr;
  logic [7:0] mem [MEM_DEPTH], next_mem [MEM_DEPTH];
  logic [TO_W-1:0] to_cnt, next_to_cnt;
  logic next_sda_oe, next_wr_strobe, next_timeout, to_hit;
  logic [7:0] next_wr_addr, next_wr_data, rd_word;

  // Counter wraps over the full byte; storage uses its low bits
  assign rd_word = mem[ptr[IDX_W-1:0]];
  // Oscillator stopped holds the counter at zero
  assign to_hit = osc && !scl && (to_cnt == TO_LAST);

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_rw = rw;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_tx = tx;
    next_ptr = ptr;
    next_mem = mem;
    next_sda_oe = sda_oe;
    next_wr_strobe = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_timeout = 1'b0;
    if (!osc || scl) begin
      next_to_cnt = TO_ZERO;
    end else if (to_cnt != TO_FULL) begin
      next_to_cnt = to_cnt + TO_W'(1);
    end else begin
      next_to_cnt = to_cnt;
    end
    if (to_hit) begin
      next_timeout = 1'b1;
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      next_state = ST_RX;
      next_kind = KIND_DEV;
      next_rw = 1'b0;
      next_bit_cnt = BIT_CNT_ZERO;
      next_sda_oe = 1'b0;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            next_bit_cnt = BIT_CNT_ZERO;
            case (kind)
              KIND_DEV: begin
                if (shift[7:1] == SLAVE_ADDR) begin
                  next_rw = shift[0];
                  next_kind = KIND_MEM;
                  next_sda_oe = 1'b1;
                  next_state = ST_RX_ACK;
                end else begin
                  next_state = ST_IGNORE;
                end
              end
              KIND_MEM: begin
                next_ptr = shift;
                next_kind = KIND_DATA;
                next_sda_oe = 1'b1;
                next_state = ST_RX_ACK;
              end
              default: begin
                next_mem[ptr[IDX_W-1:0]] = shift;
                next_wr_strobe = 1'b1;
                next_wr_addr = ptr;
                next_wr_data = shift;
                next_ptr = ptr + 8'h01;
                next_sda_oe = 1'b1;
                next_state = ST_RX_ACK;
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              // Data comes from the counter, never from the request
              next_tx = rd_word;
              next_ptr = ptr + 8'h01;
              next_sda_oe = ~rd_word[7];
              next_bit_cnt = BIT_CNT_ZERO;
              next_state = ST_TX;
            end else begin
              next_sda_oe = 1'b0;
              next_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_state = ST_TX_ACK;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_sda_oe = ~tx[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            if (sda) begin
              next_state = ST_IGNORE;
            end else begin
              next_bit_cnt = BIT_CNT_ZERO;
            end
          end else if (scl_fall && bit_cnt == BIT_CNT_ZERO) begin
            next_tx = rd_word;
            next_ptr = ptr + 8'h01;
            next_sda_oe = ~rd_word[7];
            next_state = ST_TX;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // SCL is never driven: there is no output for it at all
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      kind <= KIND_DEV;
      rw <= 1'b0;
      bit_cnt <= BIT_CNT_ZERO;
      shift <= BYTE_ZERO;
      tx <= BYTE_ZERO;
      ptr <= PTR_RESET;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= BYTE_ZERO;
      end
      to_cnt <= TO_ZERO;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= BYTE_ZERO;
      wr_data <= BYTE_ZERO;
      bus_timeout <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      rw <= next_rw;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      tx <= next_tx;
      ptr <= next_ptr;
      mem <= next_mem;
      to_cnt <= next_to_cnt;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;
      wr_strobe <= next_wr_strobe;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      bus_timeout <= next_timeout;
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic byte_end;
  assign byte_end = state == ST_RX && !to_hit && !start_det && !stop_det && scl_fall
                    && bit_cnt == BITS_PER_BYTE;

  chk_sda_low_only: assert property (sda_out == 1'b0)
    else $error("SDA driven to a high level");
  chk_timeout_reset: assert property (to_hit |=> bus_timeout && state == ST_IDLE && !sda_oe)
    else $error("Timeout did not reset interface and free SDA");
  chk_osc_gate: assert property (!osc |=> !bus_timeout)
    else $error("Timeout with oscillator stopped");
  chk_addr_miss: assert property (byte_end && kind == KIND_DEV && shift[7:1] != SLAVE_ADDR
                                  |=> state == ST_IGNORE && !sda_oe)
    else $error("Foreign address not ignored");
  chk_addr_ack: assert property (byte_end && shift[7:1] == SLAVE_ADDR && kind == KIND_DEV
                                 |=> sda_oe && state == ST_RX_ACK && kind == KIND_MEM)
    else $error("Own address not acknowledged");
  chk_mem_addr: assert property (byte_end && kind == KIND_MEM |=> ptr == $past(shift))
    else $error("Memory address not loaded");
  chk_write_store: assert property (byte_end && kind == KIND_DATA
                                    |=> wr_strobe && wr_data == $past(shift)
                                    && ptr == wr_addr + 8'h01)
    else $error("Data byte not stored at counter");
  chk_read_word: assert property (state == ST_RX_ACK && rw && scl_fall && !to_hit
                                  && !start_det && !stop_det
                                  |=> tx == $past(rd_word) && state == ST_TX)
    else $error("Read byte not taken from counter");
  chk_nack_free: assert property (state == ST_TX_ACK && scl_rise && sda && !to_hit
                                  && !start_det && !stop_det
                                  |=> (state == ST_IGNORE && !sda_oe) [*2])
    else $error("SDA still driven after NACK");
  chk_oe_on_fall: assert property ($changed(sda_oe) |-> $past(scl_fall) || $past(to_hit)
                                   || $past(start_det) || $past(stop_det))
    else $error("SDA changed outside SCL fall");

  cov_write: cover property (wr_strobe);
  cov_read_more: cover property (state == ST_TX_ACK && scl_rise && !sda);
  cov_timeout: cover property (bus_timeout);
  cov_ignore: cover property (state == ST_RX ##1 state == ST_IGNORE);

endmodule // rts_i2c_slave

// ### design/rts_pkg.sv
// Shared constants and types of the real-time clock serial slave
package rts_pkg;

  // ***********************************************
  // Bus and byte framing
  // ***********************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h68;  // Write form d0, read form d1
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int unsigned MEM_DEPTH_DEF = 16;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // Default limits, in microseconds; no figure is fixed for them
  localparam int unsigned SCL_LOW_LIMIT_MIN_US = 25000;
  localparam int unsigned SCL_LOW_LIMIT_MAX_US = 35000;
  // Scaled per microsecond: a product with the clock rate would overflow 32 bits
  localparam int unsigned SCL_LOW_LIMIT_MAX_CYC = SCL_LOW_LIMIT_MAX_US * CYC_PER_US;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_IGNORE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } rts_state_t;

  typedef enum logic [1:0] {
    KIND_DEV,
    KIND_MEM,
    KIND_DATA
  } rts_kind_t;

endpackage

// ### design/rts_sync.sv
// Two-stage synchroniser with edge detection for the bus pins
module rts_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  import rts_pkg::*;

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // ***********************************************
  // Per-bit stages
  // ***********************************************
  // Idle bus level is high, so reset to high to avoid a false edge
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic next_meta;
    logic next_level;
    logic next_prev;
    always_comb begin
      next_meta = async_in[i];
      next_level = meta[i];
      next_prev = level[i];
    end
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        meta[i] <= 1'b1;
        level[i] <= 1'b1;
        prev[i] <= 1'b1;
      end else begin
        meta[i] <= next_meta;
        level[i] <= next_level;
        prev[i] <= next_prev;
      end
    end
    assign rise[i] = level[i] & ~prev[i];
    assign fall[i] = ~level[i] & prev[i];
  end

endmodule // rts_sync

// ### tb/rts_i2c_master.sv
// Behavioural bus master that drives the serial clock and shares the data wire
module rts_i2c_master (
  output logic scl,
  output logic m_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************
  // Bus conditions and bit timing
  // ***********************************************
  // Clock is push-pull and stands high between frames
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end

  // Long low phase so the slave's late answer settles before the rise
  task automatic xfer(input logic b, output logic s);
    m_low = !b;
    #120 scl = 1'b1;
    #80 s = sda;
    #40 scl = 1'b0;
    #80;
  endtask

  task automatic start();
    m_low = 1'b0;
    #160 scl = 1'b1;
    #160 m_low = 1'b1;
    #160 scl = 1'b0;
    #80;
  endtask

  task automatic stop();
    m_low = 1'b1;
    #120 scl = 1'b1;
    #160 m_low = 1'b0;
    #160;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], s);
    end
    xfer(1'b1, ack);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, s);
      d = {d[6:0], s};
    end
    xfer(nack, s);
  endtask
endmodule // rts_i2c_master

// ### tb/rts_i2c_slave_tb_top.sv
// Bench for the serial slave: transfers, address filter and bus timeout
module rts_i2c_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, osc_run, scl, m_low, sda_out, sda_oe, wr_strobe, bus_timeout;
  logic [7:0] wr_addr, wr_data;
  wire logic sda;
  logic [15:0] wq [$];
  int cmp_count = 0;
  int fail_count = 0;
  int to_cnt = 0;
  logic a;
  logic [7:0] d;
  localparam logic [7:0] WD [3] = '{8'ha5, 8'h5a, 8'hc3};

  // Open-drain wire with pull-up
  assign sda = ~(sda_oe | m_low);
  always #20 clk_sys = ~clk_sys;

  rts_i2c_slave #(.TIMEOUT_CYCLES(200), .MEM_DEPTH(16)) dut (.clk_sys(clk_sys), .rst(rst),
    .scl_in(scl), .sda_in(sda), .osc_run(osc_run), .sda_out(sda_out), .sda_oe(sda_oe),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .bus_timeout(bus_timeout));
  rts_i2c_master m (.scl(scl), .m_low(m_low), .sda(sda));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ***********************************************
  // Monitors
  // ***********************************************
  // Sampled mid-cycle so a one-cycle pulse is never read at its launching edge
  always @(negedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      wq.push_back({wr_addr, wr_data});
    end
    if (bus_timeout === 1'b1) begin
      to_cnt++;
    end
    if (sda_oe === 1'b1) begin
      chk("sda_out", 16'h0, {15'h0, sda_out});
    end
  end

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic point(input logic [7:0] ad);
    m.start();
    m.wr_byte(8'hd0, a);
    m.wr_byte(ad, a);
  endtask

  task automatic rd_cur(input logic [7:0] exp);
    m.start();
    m.wr_byte(8'hd1, a);
    chk("ack rd", 16'h0, {15'h0, a});
    m.rd_byte(1'b1, d);
    m.stop();
    chk("cur read", {8'h0, exp}, {8'h0, d});
  endtask

  task automatic t_write();
    m.start();
    m.wr_byte(8'hd0, a);
    chk("ack dev", 16'h0, {15'h0, a});
    m.wr_byte(8'h03, a);
    chk("ack mem", 16'h0, {15'h0, a});
    foreach (WD[i]) begin
      m.wr_byte(WD[i], a);
      chk("ack data", 16'h0, {15'h0, a});
    end
    m.stop();
    chk("store count", 16'h3, 16'(wq.size()));
    foreach (WD[i]) begin
      chk("stored", {8'h03 + 8'(i), WD[i]}, wq.pop_front());
    end
  endtask

  task automatic t_cur_read();
    point(8'h03);
    m.stop();
    chk("no store", 16'h0, 16'(wq.size()));
    rd_cur(8'ha5);
  endtask

  task automatic t_rand_read();
    point(8'h04);
    m.start();
    m.wr_byte(8'hd1, a);
    m.rd_byte(1'b0, d);
    chk("rand 1", 16'h005a, {8'h0, d});
    m.rd_byte(1'b1, d);
    chk("rand 2", 16'h00c3, {8'h0, d});
    #200;
    chk("nack release", 16'h0, {15'h0, sda_oe});
    m.stop();
  endtask

  task automatic t_bad_addr();
    m.start();
    m.wr_byte(8'hd2, a);
    chk("bad addr", 16'h1, {15'h0, a});
    m.wr_byte(8'h05, a);
    m.wr_byte(8'hd0, a);
    chk("ignored", 16'h1, {15'h0, a});
    m.stop();
    chk("no store", 16'h0, 16'(wq.size()));
  endtask

  // Slave is left driving a 0 bit while the clock is held low
  task automatic t_timeout();
    point(8'h04);
    m.start();
    m.wr_byte(8'hd1, a);
    @(negedge clk_sys);
    osc_run = 1'b0;
    to_cnt = 0;
    repeat (300) @(negedge clk_sys);
    chk("osc off", 16'h0, 16'(to_cnt));
    chk("held", 16'h1, {15'h0, sda_oe});
    osc_run = 1'b1;
    repeat (250) @(negedge clk_sys);
    chk("timeout", 16'h1, 16'(to_cnt));
    chk("released", 16'h0, {15'h0, sda_oe});
    m.stop();
    point(8'h04);
    m.stop();
    rd_cur(8'h5a);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    osc_run = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_write();
    t_cur_read();
    t_rand_read();
    t_bad_addr();
    t_timeout();
    test_done();
  end

  // Whole run needs well under 150 us
  initial begin
    #400000;
    fail_count++;
    test_done();
  end
endmodule // rts_i2c_slave_tb_top
